// File: irqc_ctrl.v
// interrupt priority controller with apb register slave and core call interface
//
// Function
// RULE1: six sources, two pins, three timers, serial; each gated by own enable.
// RULE2: global gate bit 7 clear blocks all; set lets each enable decide.
// RULE3: enable bit 7 gate, bit 6 unused, bits 5..0 per source, reset zero.
// RULE4: each source has one of four levels from low and high priority bits.
// RULE5: level is two bits, high register bit is msb; three is highest.
// RULE6: preempt only by strictly higher level; top level never preempted.
// RULE7: higher level wins; ties broken by lower vector address.
// RULE8: vectors 0000, 0003, 000B, 0013, 001B, 0023, 002B hex.
// RULE9: each pin level or edge sensitive by type bit; request held in flag.
// RULE10: pin flag cleared on vectoring only in edge mode; level mode follows pin.
// RULE11: timer 0/1 flags set on rollover (not timer 0 split); cleared on vectoring.
// RULE12: timer 2 and serial requests are ORs of two flags, none cleared on vectoring.
// RULE13: software writes set or clear flags like hardware does.
// RULE14: poll in last instruction cycle using values registered the cycle before.
// RULE15: no call while equal/higher active, return or register write, or flash idle.
// RULE16: after return or enable/priority access, one more instruction runs first; the code blocks on enable/priority writes only, not on reads.
// RULE17: blocked requests are not remembered; each poll is new.
// RULE18: accepted request makes the core insert a four cycle call next.
// RULE19: single interrupt latency above 5 and below 14 cycles.
// RULE20: priority registers use bits 5..0 per source, bits 7..6 unused, reset zero.
// RULE21: track active levels; return releases the highest active level.
`timescale 1ns/10ps
`include "irqc_defs.vh"

module irqc_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        ext_irq_pin0_n,
    input  wire        ext_irq_pin1_n,
    input  wire        timer0_rollover,
    input  wire        timer0_split_mode,
    input  wire        timer1_rollover,
    input  wire        timer2_ovf_set,
    input  wire        timer2_ext_set,
    input  wire        rx_done_set,
    input  wire        tx_done_set,
    input  wire        cpu_last_cycle,
    input  wire        cpu_return_from_irq,
    input  wire        flash_self_program_idle,
    output reg         vector_call,
    output reg  [15:0] vector_addr,
    output reg  [1:0]  service_level,
    output reg         service_active,
    output reg  [9:0]  irq_flags
);

    ////////////////////////////////////////////////////////////////////////////
    // registers and state

    reg  [7:0]  enable_q;
    reg  [5:0]  prio_low_q;
    reg  [5:0]  prio_high_q;
    reg  [9:0]  flag_q;
    reg  [3:0]  active_q;
    reg         blk_q;
    reg  [2:0]  sync0_q;
    reg  [2:0]  sync1_q;
    reg         pin0_q;
    reg         pin1_q;

    wire        apb_acc  = psel & penable & pready;
    wire        apb_wr   = apb_acc & pwrite & pstrb[0];
    wire [11:0] addr_w   = paddr[11:0];
    wire        hit_en   = (addr_w == `IRQC_ADDR_ENABLE);
    wire        hit_pl   = (addr_w == `IRQC_ADDR_PRIO_LOW);
    wire        hit_ph   = (addr_w == `IRQC_ADDR_PRIO_HIGH);
    wire        hit_fl   = (addr_w == `IRQC_ADDR_FLAGS);
    wire        hit_st   = (addr_w == `IRQC_ADDR_STATUS);
    wire        hit_any  = hit_en | hit_pl | hit_ph | hit_fl | hit_st;
    wire        wr_fl_lo = apb_wr & hit_fl;
    wire        wr_fl_hi = apb_acc & pwrite & pstrb[1] & hit_fl;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: no wait states, pready always from a flop

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_any;
            prdata  <= 32'h0000_0000;
            // read data is fetched in the setup cycle so that it stands
            // together with pready for the whole access cycle
            if (psel && !penable && !pwrite) begin
                case (1'b1)
                    hit_en: prdata <= {24'h000000, enable_q};
                    hit_pl: prdata <= {26'h0, prio_low_q};
                    hit_ph: prdata <= {26'h0, prio_high_q};
                    hit_fl: prdata <= {22'h0, flag_q};
                    hit_st: prdata <= {27'h0, blk_q, active_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // RULE3: enable layout and reset
    // RULE20: priority layout and reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_q    <= `IRQC_RST8;
            prio_low_q  <= `IRQC_RST6;
            prio_high_q <= `IRQC_RST6;
        end else begin
            if (apb_wr && hit_en) begin
                enable_q <= {pwdata[`IRQC_EN_GATE_BIT], 1'b0, pwdata[`IRQC_EN_SRC_MSB:0]};
            end
            if (apb_wr && hit_pl) begin
                prio_low_q <= pwdata[`IRQC_EN_SRC_MSB:0];
            end
            if (apb_wr && hit_ph) begin
                prio_high_q <= pwdata[`IRQC_EN_SRC_MSB:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers; the filtered level moves only when stages 2 and 3 agree

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync0_q <= 3'h7;
            sync1_q <= 3'h7;
            pin0_q  <= 1'b1;
            pin1_q  <= 1'b1;
        end else begin
            sync0_q <= {sync0_q[1:0], ext_irq_pin0_n};
            sync1_q <= {sync1_q[1:0], ext_irq_pin1_n};
            if (sync0_q[1] == sync0_q[2]) begin
                pin0_q <= sync0_q[2];
            end
            if (sync1_q[1] == sync1_q[2]) begin
                pin1_q <= sync1_q[2];
            end
        end
    end

    wire fall0 = pin0_q & (sync0_q[1] == sync0_q[2]) & ~sync0_q[2];
    wire fall1 = pin1_q & (sync1_q[1] == sync1_q[2]) & ~sync1_q[2];

    ////////////////////////////////////////////////////////////////////////////
    // request, level and arbitration

    wire [5:0] src_flag;
    wire [5:0] src_req;
    wire [1:0] src_lvl [0:5];

    // RULE12: paired flags ored into one request
    assign src_flag[`IRQC_SRC_EXT0] = flag_q[`IRQC_FL_EXT0_REQ];
    assign src_flag[`IRQC_SRC_TMR0] = flag_q[`IRQC_FL_TMR0_OVF];
    assign src_flag[`IRQC_SRC_EXT1] = flag_q[`IRQC_FL_EXT1_REQ];
    assign src_flag[`IRQC_SRC_TMR1] = flag_q[`IRQC_FL_TMR1_OVF];
    assign src_flag[`IRQC_SRC_SER]  = flag_q[`IRQC_FL_RX_DONE] | flag_q[`IRQC_FL_TX_DONE];
    assign src_flag[`IRQC_SRC_TMR2] = flag_q[`IRQC_FL_TMR2_OVF] | flag_q[`IRQC_FL_TMR2_EXT];

    genvar gi;
    generate
        for (gi = 0; gi < `IRQC_NSRC; gi = gi + 1) begin : g_src
            // RULE1: per source enable
            // RULE2: global gate over all sources
            assign src_req[gi] = enable_q[`IRQC_EN_GATE_BIT] & enable_q[gi] & src_flag[gi];
            // RULE4: level from both priority registers
            // RULE5: high register bit is msb
            assign src_lvl[gi] = {prio_high_q[gi], prio_low_q[gi]};
        end
    endgenerate

    reg        win_vld;
    reg  [2:0] win_idx;
    reg  [1:0] win_lvl;
    integer    k;

    // RULE7: higher level first, lower index breaks ties
    always @* begin
        win_vld = 1'b0;
        win_idx = 3'h0;
        win_lvl = 2'h0;
        for (k = `IRQC_NSRC - 1; k >= 0; k = k - 1) begin
            if (src_req[k] && (!win_vld || src_lvl[k] >= win_lvl)) begin
                win_vld = 1'b1;
                win_idx = k[2:0];
                win_lvl = src_lvl[k];
            end
        end
    end

    // highest level in service, used for preemption
    reg        act_any;
    reg  [1:0] act_lvl;
    // own loop index, so that no variable is driven from two processes
    integer    lvl_i;
    always @* begin
        act_any = |active_q;
        act_lvl = 2'h0;
        for (lvl_i = 0; lvl_i < `IRQC_NLVL; lvl_i = lvl_i + 1) begin
            if (active_q[lvl_i]) begin
                act_lvl = lvl_i[1:0];
            end
        end
    end

    // RULE6: only a strictly higher level preempts
    wire preempt_ok = ~act_any | (win_lvl > act_lvl);

    // RULE16: block marks the instruction that touched enable/priority or returns
    wire blk_now = blk_q | cpu_return_from_irq | (apb_wr & (hit_en | hit_pl | hit_ph));

    // RULE14: polled in the last cycle on registered flags
    // RULE15: three blocking conditions
    // RULE17: no memory of a blocked request
    wire take = cpu_last_cycle & win_vld & preempt_ok & ~blk_now & ~flash_self_program_idle;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blk_q <= 1'b0;
        end else if (cpu_last_cycle) begin
            blk_q <= 1'b0;
        end else begin
            blk_q <= blk_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // active level stack

    reg [3:0] active_d;
    always @* begin
        active_d = active_q;
        // RULE21: return releases the highest active level
        if (cpu_last_cycle && cpu_return_from_irq && act_any) begin
            active_d[act_lvl] = 1'b0;
        end
        if (take) begin
            active_d[win_lvl] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_q <= `IRQC_RST4;
        end else begin
            active_q <= active_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request flags; a hardware set beats a software clear in the same cycle

    wire clr_ext0 = take & (win_idx == `IRQC_SRC_EXT0);
    wire clr_tmr0 = take & (win_idx == `IRQC_SRC_TMR0);
    wire clr_ext1 = take & (win_idx == `IRQC_SRC_EXT1);
    wire clr_tmr1 = take & (win_idx == `IRQC_SRC_TMR1);

    reg [9:0] flag_d;
    always @* begin
        flag_d = flag_q;
        // RULE13: software writes act like hardware updates
        if (wr_fl_lo) begin
            flag_d[7:0] = pwdata[7:0];
        end
        if (wr_fl_hi) begin
            flag_d[9:8] = pwdata[9:8];
        end
        // RULE9: type bit picks level or edge
        // RULE10: edge flag cleared on vectoring, level flag follows pin
        if (flag_q[`IRQC_FL_EXT0_TYPE]) begin
            if (clr_ext0) begin
                flag_d[`IRQC_FL_EXT0_REQ] = 1'b0;
            end
            // a new edge in the vectoring cycle is kept, not lost
            if (fall0) begin
                flag_d[`IRQC_FL_EXT0_REQ] = 1'b1;
            end
        end else begin
            flag_d[`IRQC_FL_EXT0_REQ] = ~pin0_q;
        end
        if (flag_q[`IRQC_FL_EXT1_TYPE]) begin
            if (clr_ext1) begin
                flag_d[`IRQC_FL_EXT1_REQ] = 1'b0;
            end
            if (fall1) begin
                flag_d[`IRQC_FL_EXT1_REQ] = 1'b1;
            end
        end else begin
            flag_d[`IRQC_FL_EXT1_REQ] = ~pin1_q;
        end
        // RULE11: rollover sets, vectoring clears; split timer 0 does not set
        if (clr_tmr0) begin
            flag_d[`IRQC_FL_TMR0_OVF] = 1'b0;
        end
        if (timer0_rollover && !timer0_split_mode) begin
            flag_d[`IRQC_FL_TMR0_OVF] = 1'b1;
        end
        if (clr_tmr1) begin
            flag_d[`IRQC_FL_TMR1_OVF] = 1'b0;
        end
        if (timer1_rollover) begin
            flag_d[`IRQC_FL_TMR1_OVF] = 1'b1;
        end
        // RULE12: these four are only cleared by software
        if (timer2_ovf_set) begin
            flag_d[`IRQC_FL_TMR2_OVF] = 1'b1;
        end
        if (timer2_ext_set) begin
            flag_d[`IRQC_FL_TMR2_EXT] = 1'b1;
        end
        if (rx_done_set) begin
            flag_d[`IRQC_FL_RX_DONE] = 1'b1;
        end
        if (tx_done_set) begin
            flag_d[`IRQC_FL_TX_DONE] = 1'b1;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_q <= `IRQC_RST10;
        end else begin
            flag_q <= flag_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // core call interface; the core turns the pulse into its four cycle call

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_call    <= 1'b0;
            vector_addr    <= `IRQC_VEC_RESET;
            service_level  <= 2'h0;
            service_active <= 1'b0;
            irq_flags      <= `IRQC_RST10;
        end else begin
            // RULE18: one pulse asks for the inserted call
            // RULE19: issued the cycle after the poll so latency stays in range
            vector_call <= take;
            if (take) begin
                // RULE8: base plus eight per source
                vector_addr <= `IRQC_VEC_BASE + ({13'h0, win_idx} << `IRQC_VEC_STRIDE_SH);
            end
            service_level  <= act_lvl_d(active_d);
            service_active <= |active_d;
            irq_flags      <= flag_d;
        end
    end

    function [1:0] act_lvl_d;
        input [3:0] a;
        integer j;
        begin
            act_lvl_d = 2'h0;
            for (j = 0; j < `IRQC_NLVL; j = j + 1) begin
                if (a[j]) act_lvl_d = j[1:0];
            end
        end
    endfunction

endmodule // irqc_ctrl

// File: irqc_defs.vh
// constants for the interrupt priority controller
`ifndef IRQC_DEFS_VH
`define IRQC_DEFS_VH

// register indices as printed; byte address is four times the index
`define IRQC_IDX_ENABLE      8'hA8
`define IRQC_IDX_PRIO_LOW    8'hB8
`define IRQC_IDX_PRIO_HIGH   8'hB7
`define IRQC_IDX_FLAGS       8'hC0
`define IRQC_IDX_STATUS      8'hC1
`define IRQC_ADDR_W          12
`define IRQC_ADDR_ENABLE     12'h2A0
`define IRQC_ADDR_PRIO_LOW   12'h2E0
`define IRQC_ADDR_PRIO_HIGH  12'h2DC
`define IRQC_ADDR_FLAGS      12'h300
`define IRQC_ADDR_STATUS     12'h304

`define IRQC_NSRC            6
`define IRQC_NLVL            4
`define IRQC_RST8            8'h00
`define IRQC_RST6            6'h00
`define IRQC_RST10           10'h000
`define IRQC_RST4            4'h0

// enable register layout
`define IRQC_EN_GATE_BIT     7
`define IRQC_EN_SRC_MSB      5

// source indices, also the polling order and bit order
`define IRQC_SRC_EXT0        0
`define IRQC_SRC_TMR0        1
`define IRQC_SRC_EXT1        2
`define IRQC_SRC_TMR1        3
`define IRQC_SRC_SER         4
`define IRQC_SRC_TMR2        5

// flag register layout (software view)
`define IRQC_FL_EXT0_TYPE    0
`define IRQC_FL_EXT1_TYPE    1
`define IRQC_FL_EXT0_REQ     2
`define IRQC_FL_EXT1_REQ     3
`define IRQC_FL_TMR0_OVF     4
`define IRQC_FL_TMR1_OVF     5
`define IRQC_FL_TMR2_OVF     6
`define IRQC_FL_TMR2_EXT     7
`define IRQC_FL_RX_DONE      8
`define IRQC_FL_TX_DONE      9
`define IRQC_FL_W            10

// vector table
`define IRQC_VEC_RESET       16'h0000
`define IRQC_VEC_BASE        16'h0003
`define IRQC_VEC_STRIDE_SH   3

`endif

// File: irqc_properties.sv
// port assertions for the interrupt priority controller
`timescale 1ns/10ps
module irqc_props (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        timer1_rollover,
    input wire        cpu_last_cycle,
    input wire        cpu_return_from_irq,
    input wire        flash_self_program_idle,
    input wire        vector_call,
    input wire [15:0] vector_addr,
    input wire [1:0]  service_level,
    input wire        service_active,
    input wire [9:0]  irq_flags
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    a_call_pulse: assert property (vector_call |=> !vector_call)
        else $error("vector call held past one cycle");
    a_call_poll: assert property (vector_call |-> $past(cpu_last_cycle))
        else $error("vector call without a polling cycle");
    a_call_ret: assert property (vector_call |-> !$past(cpu_return_from_irq))
        else $error("vector call after a return instruction");
    a_call_flash: assert property (vector_call |-> !$past(flash_self_program_idle))
        else $error("vector call while core held idle");
    a_vec_legal: assert property (vector_call |-> vector_addr[2:0] == 3'h3 && vector_addr <= 16'h002B)
        else $error("vector address outside table");
    a_call_active: assert property (vector_call |-> service_active)
        else $error("call without level in service");
    a_preempt_up: assert property (vector_call && $past(service_active)
        |-> service_level > $past(service_level))
        else $error("preemption by equal or lower level");
    a_tmr_clear: assert property (vector_call && vector_addr == 16'h001B && !$past(timer1_rollover)
        |-> !irq_flags[5])
        else $error("timer flag kept after vectoring");
    a_ser_kept: assert property (vector_call && vector_addr == 16'h0023 && !$past(psel)
        |-> irq_flags[9:8] != 2'h0)
        else $error("serial flags cleared by vectoring");
    c_nested: cover property (vector_call && $past(service_active));
    c_tmr2: cover property (vector_call && vector_addr == 16'h002B);
    c_ext0: cover property (vector_call && vector_addr == 16'h0003);
endmodule // irqc_props

// File: irqc_core.sv
// behavioural instruction sequencer on the far side of the controller
`timescale 1ns/10ps
module irqc_core (
    input wire  pclk,
    input wire  presetn,
    input wire  slow,
    input wire  ret_req,
    input wire  vector_call,
    output wire cpu_last_cycle,
    output wire cpu_return_from_irq
);
    reg [2:0] cnt_q;
    reg       ret_q;
    reg [2:0] depth_q;
    assign cpu_last_cycle = cnt_q == 3'h1 && !vector_call;
    assign cpu_return_from_irq = ret_q && !vector_call;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 3'h1;
            ret_q <= 1'b0;
            depth_q <= 3'h0;
        end else if (vector_call) begin
            cnt_q <= 3'h3;
            ret_q <= 1'b0;
            depth_q <= depth_q + 3'h1;
        end else if (cnt_q == 3'h1) begin
            if (ret_q)
                depth_q <= depth_q - 3'h1;
            ret_q <= ret_req && depth_q > {2'h0, ret_q};
            // slow mode: lengths 1..5, longest instruction
            cnt_q <= slow ? 3'h1 + 3'($urandom % 5) : 3'h1;
        end else
            cnt_q <= cnt_q - 3'h1;
    end
endmodule // irqc_core

// File: tb_top.sv
// self-checking bench for the interrupt priority controller
`timescale 1ns/10ps
`include "irqc_defs.vh"
module tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, rd;
    logic [3:0]  pstrb = 4'hF, hs = 0;
    logic        ext_irq_pin0_n = 1, ext_irq_pin1_n = 1, timer0_rollover = 0, timer0_split_mode = 0;
    logic        timer1_rollover = 0, flash_self_program_idle = 0, slow = 0, ret_req = 0, err, hit;
    logic [5:0]  pl, ph, en, m;
    logic [15:0] va;
    logic [1:0]  sl;
    wire [31:0]  prdata;
    wire         pready, pslverr, cpu_last_cycle, cpu_return_from_irq, vector_call, service_active;
    wire [15:0]  vector_addr;
    wire [1:0]   service_level;
    wire [9:0]   irq_flags;
    int          fails = 0, tests_run = 0, w, k;
    always #2.5 pclk = ~pclk;
    irqc_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .ext_irq_pin0_n, .ext_irq_pin1_n, .timer0_rollover, .timer0_split_mode, .timer1_rollover,
        .timer2_ovf_set(hs[0]), .timer2_ext_set(hs[1]), .rx_done_set(hs[2]), .tx_done_set(hs[3]),
        .cpu_last_cycle, .cpu_return_from_irq, .flash_self_program_idle, .vector_call, .vector_addr,
        .service_level, .service_active, .irq_flags);
    irqc_core u_core (.pclk, .presetn, .slow, .ret_req, .vector_call, .cpu_last_cycle, .cpu_return_from_irq);
    ////////////////////////////////////////////////////////////
    task complete_run;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {20'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task wcall(input int n);
        hit = 0;
        repeat (n) begin
            @(posedge pclk);
            if (vector_call === 1'b1 && !hit) begin
                hit = 1;
                va = vector_addr;
                sl = service_level;
            end
        end
    endtask
    task ret;
        int n;
        n = 0;
        ret_req <= 1'b1;
        while (service_active !== 1'b0 && n++ < 200) @(posedge pclk);
        chk("returned", 0, service_active);
        ret_req <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [1:0] lv(input int s);
        lv = {ph[s], pl[s]};
    endfunction
    // lower index wins ties, as it has the lower vector
    function automatic int win(input logic [5:0] q);
        win = -1;
        for (int s = 5; s >= 0; s--)
            if (q[s] && (win < 0 || lv(s) >= lv(win)))
                win = s;
    endfunction
    function automatic logic [31:0] fv(input logic [5:0] q);
        fv = {23'h0, q[4], 1'b0, q[5], q[3], q[1], q[2], q[0], 2'h3};
    endfunction
    ////////////////////////////////////////////////////////////
    initial begin
        #(20000 * 5);
        fails++;
        complete_run;
    end
    initial begin
        void'($urandom(32'hA6437ACA));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `IRQC_ADDR_ENABLE, 0); chk("enable reset", 0, rd);
        apb(0, `IRQC_ADDR_PRIO_LOW, 0); chk("prio low reset", 0, rd);
        apb(0, `IRQC_ADDR_PRIO_HIGH, 0); chk("prio high reset", 0, rd);
        apb(0, 12'hFF0, 0); chk("unmapped error", 1, err);
        apb(1, `IRQC_ADDR_ENABLE, 32'hFF); apb(0, `IRQC_ADDR_ENABLE, 0); chk("enable bits", 32'hBF, rd);
        apb(1, `IRQC_ADDR_PRIO_HIGH, 32'hFF); apb(0, `IRQC_ADDR_PRIO_HIGH, 0); chk("prio bits", 32'h3F, rd);
        apb(1, `IRQC_ADDR_ENABLE, 32'h3F); apb(1, `IRQC_ADDR_FLAGS, fv(6'h3F));
        wcall(30); chk("gate off", 0, hit);
        for (int t = 0; t < 24; t++) begin
            slow <= t[0];
            {pl, ph, en, m} = $urandom;
            apb(1, `IRQC_ADDR_ENABLE, {26'h0, en}); apb(1, `IRQC_ADDR_PRIO_LOW, {26'h0, pl});
            apb(1, `IRQC_ADDR_PRIO_HIGH, {26'h0, ph}); apb(1, `IRQC_ADDR_FLAGS, fv(m));
            apb(1, `IRQC_ADDR_ENABLE, {24'h0, 2'h2, en});
            w = win(m & en);
            wcall(40); chk("call taken", w >= 0, hit);
            if (hit) begin
                chk("vector", 3 + 8 * w, va);
                chk("level", lv(w), sl);
                apb(0, `IRQC_ADDR_STATUS, 0);
                chk("status level", 32'h1 << lv(w), rd & 32'hF);
                apb(1, `IRQC_ADDR_FLAGS, 3);
                k = $urandom % 6;
                apb(1, `IRQC_ADDR_FLAGS, fv(6'h1 << k));
                wcall(40); chk("preempt", en[k] && lv(k) > lv(w), hit);
                apb(1, `IRQC_ADDR_FLAGS, 3);
                ret;
            end
        end
        apb(1, `IRQC_ADDR_ENABLE, 32'h88);
        flash_self_program_idle <= 1'b1;
        apb(1, `IRQC_ADDR_FLAGS, 32'h23); wcall(20); chk("idle blocks", 0, hit);
        apb(1, `IRQC_ADDR_FLAGS, 3);
        flash_self_program_idle <= 1'b0;
        wcall(20); chk("not remembered", 0, hit);
        slow <= 1'b1;
        timer1_rollover <= 1'b1;
        @(posedge pclk);
        timer1_rollover <= 1'b0;
        k = 0;
        do begin @(posedge pclk); k++; end while (vector_call !== 1'b1 && k < 30);
        // counted from the rollover cycle; the call itself fills four cycles
        chk("latency", 1, k + 4 > 5 && k + 4 < 14);
        ret;
        timer0_split_mode <= 1'b1;
        timer0_rollover <= 1'b1;
        @(posedge pclk);
        timer0_rollover <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("split no flag", 0, irq_flags[4]);
        apb(1, `IRQC_ADDR_ENABLE, 32'h81); apb(1, `IRQC_ADDR_FLAGS, 0);
        ext_irq_pin0_n <= 1'b0;
        wcall(30); chk("level vector", 16'h0003, va);
        chk("level flag kept", 1, irq_flags[2]);
        ext_irq_pin0_n <= 1'b1;
        repeat (20) @(posedge pclk);
        chk("level flag follows", 0, irq_flags[2]);
        ret;
        apb(1, `IRQC_ADDR_ENABLE, 32'h84); apb(1, `IRQC_ADDR_FLAGS, 3);
        ext_irq_pin1_n <= 1'b0;
        wcall(30); chk("edge vector", 16'h0013, va);
        chk("edge flag clear", 0, irq_flags[3]);
        ext_irq_pin1_n <= 1'b1;
        ret;
        apb(1, `IRQC_ADDR_ENABLE, 32'hB0);
        for (int i = 0; i < 4; i++) begin
            hs <= 4'h1 << i;
            @(posedge pclk);
            hs <= 4'h0;
            wcall(30); chk("or vector", i < 2 ? 16'h002B : 16'h0023, va);
            chk("flag kept", 1, irq_flags[6 + i]);
            apb(1, `IRQC_ADDR_FLAGS, 3);
            ret;
        end
        complete_run;
    end
endmodule // tb_top
bind irqc_ctrl irqc_props u_props (.pclk, .presetn, .psel, .timer1_rollover, .cpu_last_cycle,
    .cpu_return_from_irq, .flash_self_program_idle, .vector_call, .vector_addr, .service_level,
    .service_active, .irq_flags);
